// File: logic/upfc_pkg.sv
package upfc_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam int unsigned APB_AW         = 12;
   localparam logic [11:0] SW_CTRL_ADDR   = 12'h000;
   localparam logic [11:0] FOCTL_ADDR     = 12'h004;
   localparam logic [11:0] FOSTAT_ADDR    = 12'h008;

   // Field positions
   localparam int unsigned NOLD_HRST_BIT  = 0;
   localparam int unsigned SW_SEL_BIT     = 0;
   localparam int unsigned FO_EN_BIT      = 0;
   localparam int unsigned CUR_PORT_BIT   = 1;
   localparam int unsigned CHANGED_BIT    = 2;
   localparam int unsigned INITIATED_BIT  = 3;

   // ------------------------------------------------------------
   // Boot switch modes
   // ------------------------------------------------------------
   localparam logic [3:0] MODE_NORMAL     = 4'h0;
   localparam logic [3:0] MODE_NORMAL_EE  = 4'h1;
   localparam logic [3:0] MODE_FO_P0      = 4'h2;
   localparam logic [3:0] MODE_FO_P2      = 4'h3;
   localparam logic [3:0] MODE_EE_FO_P0   = 4'h4;
   localparam logic [3:0] MODE_EE_FO_P2   = 4'h5;

   // Lane mux select values
   localparam logic PORT_SEL_0 = 1'b0;
   localparam logic PORT_SEL_2 = 1'b1;

   // Cycles the link is held in Detect before the lanes move
   localparam logic [3:0] DETECT_HOLD_CYC = 4'h4;

   // Reset values
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // Trigger kinds, index into pending vector
   typedef enum logic [1:0]
   {
      TRIG_SW  = 2'h0,
      TRIG_SIG = 2'h1,
      TRIG_TMR = 2'h2
   } upfc_trig_t;

   // Failover sequence, Gray along the path
   typedef enum logic [1:0]
   {
      ST_IDLE   = 2'h0,
      ST_DETECT = 2'h1,
      ST_SWITCH = 2'h3,
      ST_TRAIN  = 2'h2
   } upfc_state_t;

endpackage : upfc_pkg

// File: logic/upfc_top.sv
`timescale 1ns/1ps
module upfc_top
(
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       hot_reset,
   input  wire logic [3:0]                 boot_switch_mode_inputs,
   input  wire logic                       port0_x8_merged,
   input  wire logic                       sig_failover_req,
   input  wire logic                       sig_port_sel,
   input  wire logic                       tmr_failover_req,
   input  wire logic                       stack0_link_up,
   input  wire logic                       stack0_link_led,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [upfc_pkg::APB_AW-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   output logic                            serdes_mux_sel,
   output logic      [3:0]                 port_disable,
   output logic                            ltssm_force_detect,
   output logic                            dl_down,
   output logic                            replay_flush,
   output logic                            queue_flush,
   output logic                            train_start,
   output logic                            hot_reset_req,
   output logic                            port0_link_led,
   output logic                            failover_busy
);
   import upfc_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   upfc_state_t state_q, state_d;
   upfc_trig_t  cur_type_q;
   logic        boot_done_q;
   logic        fo_mode_q;
   logic        cur_port_q;
   logic        target_q;
   logic        sw_sel_q;
   logic        nold_hrst_q;
   logic        changed_q;
   logic        initiated_q;
   logic [2:0]  pend_q;
   logic [3:0]  cnt_q;
   logic        led_q;
   logic [31:0] rdata_q;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire setup_w  = psel & ~penable;
   wire access_w = psel & penable;
   wire hit_ctl  = (paddr == SW_CTRL_ADDR);
   wire hit_fo   = (paddr == FOCTL_ADDR);
   wire hit_st   = (paddr == FOSTAT_ADDR);
   wire mapped_w = hit_ctl | hit_fo | hit_st;
   wire wr_w     = access_w & pwrite;
   wire wr_ctl   = wr_w & hit_ctl;
   wire wr_fo    = wr_w & hit_fo;
   wire wr_st    = wr_w & hit_st;

   // Zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = access_w & ~mapped_w;
   assign prdata  = rdata_q;

   // Read data image of the three registers
   wire [31:0] ctl_img = {31'h0000_0000, nold_hrst_q};
   wire [31:0] fo_img  = {31'h0000_0000, sw_sel_q};
   wire [31:0] st_img  = {28'h000_0000, initiated_q, changed_q, cur_port_q, fo_mode_q};
   wire [31:0] rd_mux  = hit_ctl ? ctl_img :
                         hit_fo  ? fo_img  :
                         hit_st  ? st_img  : 32'h0000_0000;

   // ------------------------------------------------------------
   // Boot mode decode
   // ------------------------------------------------------------
   wire strap_fo = (boot_switch_mode_inputs == MODE_FO_P0) |
                   (boot_switch_mode_inputs == MODE_FO_P2) |
                   (boot_switch_mode_inputs == MODE_EE_FO_P0) |
                   (boot_switch_mode_inputs == MODE_EE_FO_P2);
   wire strap_p2 = (boot_switch_mode_inputs == MODE_FO_P2) |
                   (boot_switch_mode_inputs == MODE_EE_FO_P2);

   // ------------------------------------------------------------
   // Trigger qualification
   // ------------------------------------------------------------
   wire busy_w   = (state_q != ST_IDLE);
   // Only a real change that names the other port counts
   wire sw_req_w = boot_done_q & fo_mode_q & wr_fo &
                   (pwdata[SW_SEL_BIT] != sw_sel_q) &
                   (pwdata[SW_SEL_BIT] != cur_port_q);
   wire [2:0] req_w = {tmr_failover_req & fo_mode_q,
                       sig_failover_req & fo_mode_q,
                       sw_req_w};
   // Drop a request of the kind now running, keep the others
   wire [2:0] drop_w = busy_w ? (3'b001 << cur_type_q) : 3'b000;
   wire [2:0] keep_w = req_w & ~drop_w;

   // Fixed priority among held requests
   upfc_trig_t pick_w;
   assign pick_w = pend_q[TRIG_SW]  ? TRIG_SW  :
                   pend_q[TRIG_SIG] ? TRIG_SIG : TRIG_TMR;
   wire pick_tgt = (pick_w == TRIG_SW)  ? sw_sel_q :
                   (pick_w == TRIG_SIG) ? sig_port_sel : ~cur_port_q;
   wire start_w  = (state_q == ST_IDLE) & fo_mode_q & (|pend_q) &
                   (pick_tgt != cur_port_q);
   wire [2:0] pick_oh = 3'b001 << pick_w;
   // An idle pick naming the current port retires silently
   wire [2:0] retire_w = ((state_q == ST_IDLE) & (|pend_q)) ? pick_oh : 3'b000;
   wire detect_end = (state_q == ST_DETECT) & (cnt_q == 4'h1);

   // ------------------------------------------------------------
   // Sequence next state
   // ------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE   : if (start_w) state_d = ST_DETECT;
         ST_DETECT : if (detect_end) state_d = ST_SWITCH;
         ST_SWITCH : state_d = ST_TRAIN;
         ST_TRAIN  : if (stack0_link_up) state_d = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // Strap capture, one cycle after fundamental reset release
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         boot_done_q <= 1'b0;
         fo_mode_q   <= 1'b0;
      end
      else if (!boot_done_q)
      begin
         boot_done_q <= 1'b1;
         fo_mode_q   <= strap_fo;
      end
   end

   // ------------------------------------------------------------
   // Failover sequencer; hot reset deliberately not wired in
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q    <= ST_IDLE;
         cur_type_q <= TRIG_SW;
         pend_q     <= 3'b000;
         cnt_q      <= 4'h0;
         target_q   <= PORT_SEL_0;
         cur_port_q <= PORT_SEL_0;
      end
      else
      begin
         state_q <= state_d;
         // New requests win over the retirement of a pick
         pend_q  <= (pend_q & ~retire_w) | keep_w;
         if (!boot_done_q)
            cur_port_q <= strap_fo & strap_p2;
         if (start_w)
         begin
            cur_type_q <= pick_w;
            target_q   <= pick_tgt;
            cnt_q      <= DETECT_HOLD_CYC;
         end
         else if (state_q == ST_DETECT)
            cnt_q <= cnt_q - 4'h1;
         if (state_q == ST_SWITCH)
            cur_port_q <= target_q;
      end
   end

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   // Control bit is ordinary state and clears on hot reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         nold_hrst_q <= 1'b0;
      else if (hot_reset)
         nold_hrst_q <= 1'b0;
      else if (wr_ctl)
         nold_hrst_q <= pwdata[NOLD_HRST_BIT];
   end

   // Select field tracks the boot port so a first write is a true change
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sw_sel_q <= PORT_SEL_0;
      else if (!boot_done_q)
         sw_sel_q <= strap_fo & strap_p2;
      else if (wr_fo)
         sw_sel_q <= pwdata[SW_SEL_BIT];
   end

   // Sticky status flags, write one to clear, set beats clear
   wire set_chg  = (state_q == ST_SWITCH);
   wire set_init = start_w;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         changed_q   <= 1'b0;
         initiated_q <= 1'b0;
      end
      else
      begin
         changed_q   <= (changed_q & ~(wr_st & pwdata[CHANGED_BIT])) | set_chg;
         initiated_q <= (initiated_q & ~(wr_st & pwdata[INITIATED_BIT])) | set_init;
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rdata_q <= RDATA_RST;
      else if (setup_w & ~pwrite)
         rdata_q <= rd_mux;
   end

   // Upstream indicators always belong to port 0
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         led_q <= 1'b0;
      else
         led_q <= stack0_link_led;
   end

   // ------------------------------------------------------------
   // Datapath and link control outputs
   // ------------------------------------------------------------
   wire in_detect = (state_q == ST_DETECT);
   assign serdes_mux_sel     = cur_port_q;
   assign port_disable[0]    = 1'b0;
   assign port_disable[2]    = fo_mode_q;
   // Ports 1 and 3 only go when the upstream is x8 wide
   assign port_disable[1]    = fo_mode_q & port0_x8_merged;
   assign port_disable[3]    = fo_mode_q & port0_x8_merged;
   assign ltssm_force_detect = in_detect;
   assign dl_down            = in_detect;
   assign replay_flush       = in_detect;
   assign queue_flush        = in_detect;
   assign train_start        = (state_q == ST_TRAIN);
   assign hot_reset_req      = start_w & ~nold_hrst_q;
   assign port0_link_led     = led_q;
   assign failover_busy      = busy_w;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_port2_off: assert property (fo_mode_q |-> port_disable[2])
      else $error("port 2 enabled in failover mode");
   a_x8_ports_off: assert property
      (fo_mode_q && port0_x8_merged |-> port_disable == 4'he)
      else $error("x8 failover did not disable ports 1 to 3");
   a_x4_ports_kept: assert property
      (!port0_x8_merged |-> !port_disable[1] && !port_disable[3])
      else $error("x4 failover disabled port 1 or 3");
   a_led_port0: assert property
      (boot_done_q |=> port0_link_led == $past(stack0_link_led))
      else $error("port 0 indicator not following stack 0");
   a_detect_hold: assert property
      (start_w |=> (ltssm_force_detect && dl_down && queue_flush) [*4] ##1 !ltssm_force_detect)
      else $error("detect hold length wrong");
   a_mux_after_det: assert property
      (boot_done_q && $past(boot_done_q) && $changed(serdes_mux_sel)
       |-> $past(ltssm_force_detect, 2) && train_start)
      else $error("lanes moved outside the failover sequence");
   a_hrst_gate: assert property
      (start_w |-> hot_reset_req == !nold_hrst_q)
      else $error("hot reset request ignores control bit");
   a_status_read: assert property
      (setup_w && !pwrite && hit_st |=> prdata[FO_EN_BIT] == fo_mode_q
       && prdata[CUR_PORT_BIT] == cur_port_q)
      else $error("status read wrong");
   a_changed_set: assert property
      (state_q == ST_SWITCH |=> changed_q)
      else $error("change flag not set");
   a_same_drop: assert property
      (busy_w && cur_type_q == TRIG_SIG && !pend_q[TRIG_SIG] |=> !pend_q[TRIG_SIG])
      else $error("same kind request was held");
   a_other_held: assert property
      (busy_w && tmr_failover_req && fo_mode_q && cur_type_q != TRIG_TMR
       |=> pend_q[TRIG_TMR])
      else $error("other kind request lost");
   a_sw_start: assert property
      (sw_req_w && !busy_w && !(|pend_q) |=> start_w)
      else $error("software change did not start failover");
   a_off_no_start: assert property
      (!fo_mode_q |-> !start_w && !busy_w)
      else $error("failover started outside failover mode");

   c_sw_failover: cover property (sw_req_w ##[1:20] state_q == ST_TRAIN);
   c_held_request: cover property (busy_w && (|keep_w) ##[1:40] start_w);
   c_no_hot_reset: cover property (start_w && nold_hrst_q);
   c_x8_mode: cover property (fo_mode_q && port0_x8_merged && start_w);

endmodule : upfc_top

// File: tb/upfc_link_partner.sv
`timescale 1ns/1ps
module upfc_link_partner
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       train_start,
   input  wire logic       ltssm_force_detect,
   input  wire logic [7:0] train_cycles,
   output logic            link_up,
   output logic            link_led
);
   logic [7:0] cnt_q;

   // ------------------------------------------------------------
   // Root complex end of the upstream link
   // ------------------------------------------------------------
   // Training takes a set time; Detect drops the link at once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q   <= 8'h00;
         link_up <= 1'b0;
      end
      else if (ltssm_force_detect)
      begin
         cnt_q   <= 8'h00;
         link_up <= 1'b0;
      end
      else if (train_start && !link_up)
      begin
         cnt_q   <= cnt_q + 8'h01;
         link_up <= (cnt_q >= train_cycles);
      end
   end

   // Indicator varies with the count, so a stale copy shows
   assign link_led = link_up ^ cnt_q[0];

endmodule : upfc_link_partner

// File: tb/test_upstream_port_failover_control.sv
`timescale 1ns/1ps
module test_upstream_port_failover_control;
   import upfc_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        pclk = 1'b0, presetn = 1'b0, hot_reset = 1'b0, port0_x8_merged = 1'b0;
   logic        sig_failover_req = 1'b0, sig_port_sel = 1'b0, tmr_failover_req = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rd_err;
   logic [3:0]  boot_switch_mode_inputs = 4'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd_data;
   logic [7:0]  train_dly = 8'h0a;
   logic        pready, pslverr, serdes_mux_sel, ltssm_force_detect, dl_down, replay_flush;
   logic        queue_flush, train_start, hot_reset_req, port0_link_led, failover_busy;
   logic        link_up, link_led, led_prev = 1'b0, mux_prev = 1'b0, det_prev = 1'b0;
   logic [3:0]  port_disable;
   int          num_errors = 0, checks_done = 0, det_cyc = 0, hrst_cnt = 0, fo_cnt = 0;
   int          ord_err = 0, led_err = 0;

   always #4 pclk = ~pclk;

   upfc_top upfc_top_inst
   (
      .pclk(pclk), .presetn(presetn), .hot_reset(hot_reset),
      .boot_switch_mode_inputs(boot_switch_mode_inputs), .port0_x8_merged(port0_x8_merged),
      .sig_failover_req(sig_failover_req), .sig_port_sel(sig_port_sel),
      .tmr_failover_req(tmr_failover_req), .stack0_link_up(link_up),
      .stack0_link_led(link_led), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serdes_mux_sel(serdes_mux_sel), .port_disable(port_disable),
      .ltssm_force_detect(ltssm_force_detect), .dl_down(dl_down),
      .replay_flush(replay_flush), .queue_flush(queue_flush), .train_start(train_start),
      .hot_reset_req(hot_reset_req), .port0_link_led(port0_link_led),
      .failover_busy(failover_busy)
   );

   upfc_link_partner upfc_link_partner_inst
   (
      .pclk(pclk), .presetn(presetn), .train_start(train_start),
      .ltssm_force_detect(ltssm_force_detect), .train_cycles(train_dly),
      .link_up(link_up), .link_led(link_led)
   );

   // ------------------------------------------------------------
   // Monitor and shared tasks
   // ------------------------------------------------------------
   // Counts detect cycles, hot reset pulses and starts; flags bad order
   always @(posedge pclk)
   begin
      det_cyc  <= det_cyc + int'(ltssm_force_detect && dl_down && replay_flush && queue_flush);
      hrst_cnt <= hrst_cnt + int'(hot_reset_req);
      fo_cnt   <= fo_cnt + int'(ltssm_force_detect && !det_prev);
      det_prev <= ltssm_force_detect;
      mux_prev <= serdes_mux_sel;
      led_prev <= link_led;
      if (ltssm_force_detect && (serdes_mux_sel !== mux_prev || train_start))
         ord_err <= ord_err + 1;
      if (presetn && port0_link_led !== led_prev)
         led_err <= led_err + 1;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic do_reset(input logic [3:0] mode, input logic x8);
      presetn <= 1'b0;
      boot_switch_mode_inputs <= mode;
      port0_x8_merged <= x8;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask : do_reset

   // Holds the request until pready, then one idle cycle
   task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      check("pready", 32'h1, {31'h0, pready});
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb_xfer

   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp,
                         input logic err);
      apb_xfer(1'b0, a, 32'h0);
      check(what, exp, rd_data);
      check("pslverr", {31'h0, err}, {31'h0, rd_err});
   endtask : rd_chk

   task automatic req(input logic tmr, input logic sig, input logic sel);
      tmr_failover_req <= tmr;
      sig_failover_req <= sig;
      sig_port_sel <= sel;
      @(posedge pclk);
      tmr_failover_req <= 1'b0;
      sig_failover_req <= 1'b0;
      @(posedge pclk);
   endtask : req

   task automatic wait_idle();
      int n;
      n = 0;
      repeat (3) @(posedge pclk);
      while (failover_busy !== 1'b0 && n < 500)
      begin
         @(posedge pclk);
         n++;
      end
      check("busy", 32'h0, {31'h0, failover_busy});
   endtask : wait_idle

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Every boot mode; requests must do nothing outside failover modes
   task automatic t_modes();
      logic fo, p2;
      int   base;
      for (int i = 0; i < 6; i++)
      begin
         fo = (i >= 2);
         p2 = (i == 3 || i == 5);
         do_reset(4'(i), 1'b0);
         base = fo_cnt;
         rd_chk("status", FOSTAT_ADDR, {30'h0, p2, fo}, 1'b0);
         check("mux", {31'h0, p2}, {31'h0, serdes_mux_sel});
         check("disable", {29'h0, fo, 2'b00}, {28'h0, port_disable});
         if (!fo)
         begin
            apb_xfer(1'b1, FOCTL_ADDR, 32'h1);
            req(1'b1, 1'b1, 1'b1);
            wait_idle();
            check("starts", 32'(base), 32'(fo_cnt));
         end
      end
      $display("test modes done");
   endtask : t_modes

   // Software failover from port 2 back to port 0, slow link partner
   task automatic t_switch();
      int d0, h0, f0;
      do_reset(MODE_FO_P2, 1'b1);
      check("disable x8", 32'he, {28'h0, port_disable});
      port0_x8_merged <= 1'b0;
      train_dly <= 8'h30;
      d0 = det_cyc;
      h0 = hrst_cnt;
      f0 = fo_cnt;
      apb_xfer(1'b1, FOCTL_ADDR, 32'h0);
      wait_idle();
      check("detect cycles", 32'(DETECT_HOLD_CYC), 32'(det_cyc - d0));
      check("hot reset pulses", 32'h1, 32'(hrst_cnt - h0));
      check("starts", 32'h1, 32'(fo_cnt - f0));
      check("mux", 32'h0, {31'h0, serdes_mux_sel});
      check("order faults", 32'h0, 32'(ord_err));
      rd_chk("status", FOSTAT_ADDR, 32'hd, 1'b0);
      $display("test switch done");
   endtask : t_switch

   // Dropped and queued requests, hot reset, flag clearing
   task automatic t_queue();
      int h0, f0;
      do_reset(MODE_FO_P0, 1'b0);
      train_dly <= 8'h02;
      apb_xfer(1'b1, SW_CTRL_ADDR, 32'h1);
      h0 = hrst_cnt;
      f0 = fo_cnt;
      req(1'b1, 1'b0, 1'b0);
      req(1'b1, 1'b1, 1'b0);
      wait_idle();
      wait_idle();
      check("starts", 32'h2, 32'(fo_cnt - f0));
      check("mux", 32'h0, {31'h0, serdes_mux_sel});
      req(1'b1, 1'b0, 1'b0);
      wait_idle();
      apb_xfer(1'b1, FOCTL_ADDR, 32'h1);
      wait_idle();
      check("starts", 32'h3, 32'(fo_cnt - f0));
      check("hot reset pulses", 32'h0, 32'(hrst_cnt - h0));
      hot_reset <= 1'b1;
      @(posedge pclk);
      hot_reset <= 1'b0;
      @(posedge pclk);
      rd_chk("switch control", SW_CTRL_ADDR, 32'h0, 1'b0);
      rd_chk("status", FOSTAT_ADDR, 32'hf, 1'b0);
      check("mux", 32'h1, {31'h0, serdes_mux_sel});
      apb_xfer(1'b1, FOSTAT_ADDR, 32'hc);
      rd_chk("status", FOSTAT_ADDR, 32'h3, 1'b0);
      rd_chk("unmapped", 12'h00c, 32'h0, 1'b1);
      check("order faults", 32'h0, 32'(ord_err));
      check("led faults", 32'h0, 32'(led_err));
      $display("test queue done");
   endtask : t_queue

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   initial
   begin
      t_modes();
      t_switch();
      t_queue();
      report_and_stop();
   end

   // Whole run needs a few hundred cycles
   initial
   begin
      #160000;
      num_errors++;
      report_and_stop();
   end

endmodule : test_upstream_port_failover_control
